/* hw/uhc_pkg.sv */
// constants, types and register map of the usb host transfer controller
`default_nettype none
package uhc_pkg;
   localparam int unsigned REG_AW = 8;
   localparam int unsigned REG_DW = 16;

   localparam logic [7:0] OFF_MAIN_CTRL = 8'h00;
   localparam logic [7:0] OFF_OTG_CTRL  = 8'h04;
   localparam logic [7:0] OFF_EP0_CTRL  = 8'h08;
   localparam logic [7:0] OFF_TGT_ADDR  = 8'h0C;
   localparam logic [7:0] OFF_TOKEN     = 8'h10;
   localparam logic [7:0] OFF_IRQ_FLAGS = 8'h14;
   localparam logic [7:0] OFF_BD_CTRL   = 8'h18;
   localparam logic [7:0] OFF_BD_DATA   = 8'h1C;
   localparam logic [7:0] OFF_STATUS    = 8'h20;

   localparam int unsigned MAIN_HOST_EN = 3;
   localparam int unsigned OTG_DP_PU    = 7;
   localparam int unsigned OTG_DM_PU    = 6;
   localparam int unsigned OTG_DP_PD    = 5;
   localparam int unsigned OTG_DM_PD    = 4;
   localparam int unsigned OTG_VBUS_ON  = 3;
   localparam int unsigned OTG_EN       = 2;
   localparam int unsigned OTG_VBUS_DIS = 0;
   localparam int unsigned EP0_LOW_SPEED_SELECT     = 7;
   localparam int unsigned EP0_NAK_RETRY_DISABLE = 6;
   localparam int unsigned IRQ_DETACH   = 0;
   localparam int unsigned IRQ_TRN_DONE = 3;
   localparam int unsigned IRQ_STALL    = 7;
   localparam int unsigned BD_OWN       = 15;
   localparam int unsigned BD_DATA01    = 14;
   localparam int unsigned BD_PID_LSB   = 10;
   localparam int unsigned BD_CNT_W     = 7;

   localparam logic [7:0] MAIN_RESET = 8'h00;
   localparam logic [7:0] OTG_RESET  = 8'h00;
   localparam logic [7:0] EP0_RESET  = 8'h00;

   localparam logic [3:0] PID_OUT   = 4'h1;
   localparam logic [3:0] PID_SETUP = 4'hD;
   localparam logic [3:0] PID_DATA0 = 4'h3;
   localparam logic [3:0] PID_DATA1 = 4'hB;
   localparam logic [3:0] PID_ACK   = 4'h2;
   localparam logic [3:0] PID_NAK   = 4'hA;
   localparam logic [3:0] PID_STALL = 4'hE;
   localparam logic [3:0] PID_ERR   = 4'hF;

   localparam int unsigned MAX_BD_BYTES   = 64;
   localparam int unsigned CLK_PERIOD_NS  = 100;
   localparam int unsigned SE0_DETACH_NS  = 2500;
   localparam int unsigned SE0_DETACH_CYC = SE0_DETACH_NS / CLK_PERIOD_NS;
   localparam int unsigned HS_TIMEOUT_CYC = 32;

   typedef enum logic [1:0] {ST_IDLE, ST_TOKEN, ST_DATA, ST_WAIT_HS} uhc_state_e;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       last;
   } uhc_tx_s;

   typedef struct packed {
      logic       valid;
      logic [3:0] pid;
   } uhc_hs_s;
endpackage : uhc_pkg
`default_nettype wire

/* hw/uhc_sync2.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module uhc_sync2 #(
   parameter int unsigned W = 1
) (
   input  wire logic         sys_clk, // system clock
   input  wire logic         rst_n,   // async reset, active low
   input  wire logic         ce,      // clock enable
   input  wire logic [W-1:0] d,       // asynchronous input
   output var  logic [W-1:0] q        // synchronised output
);
   logic [W-1:0] meta_q;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : uhc_sync2
`default_nettype wire

/* hw/uhc_se0_timer.sv */
// detach detector: flags se0 lasting longer than the detach time
`timescale 1ns/10ps
`default_nettype none
module uhc_se0_timer
   import uhc_pkg::*;
#(
   parameter int unsigned LIMIT_CYC = SE0_DETACH_CYC
) (
   input  wire logic sys_clk, // system clock
   input  wire logic rst_n,   // async reset, active low
   input  wire logic ce,      // clock enable
   input  wire logic enable,  // host mode active
   input  wire logic se0,     // synchronised se0 level
   output var  logic detach   // one-cycle detach pulse
);
   localparam int unsigned CW = $clog2(LIMIT_CYC + 2);
   localparam logic [CW-1:0] LIMIT = CW'(LIMIT_CYC);
   logic [CW-1:0] cnt_q;

   // counter saturates above the limit so one long se0 gives one pulse
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= '0;
         detach <= 1'b0;
      end else if (ce) begin
         detach <= enable && se0 && (cnt_q == LIMIT);
         if (!enable || !se0) begin
            cnt_q <= '0;
         end else if (cnt_q <= LIMIT) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   se0_long_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ce && detach |-> $past(se0) && $past(cnt_q) == LIMIT)
      else $error("detach pulse without long se0");
endmodule : uhc_se0_timer
`default_nettype wire

/* hw/uhc_host_ctrl.sv */
// host and otg transfer control of a full-speed usb module
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module uhc_host_ctrl
   import uhc_pkg::*;
#(
   parameter int unsigned HS_TIMEOUT = HS_TIMEOUT_CYC
) (
   input  wire logic              sys_clk,                // system clock, 10 MHz
   input  wire logic              rst_n,                  // async reset, active low
   input  wire logic              ce,                     // clock enable, freezes state
   input  wire logic [REG_AW-1:0] reg_addr,               // register byte address
   input  wire logic [REG_DW-1:0] reg_wdata,              // register write data
   input  wire logic              reg_wr,                 // write strobe
   input  wire logic              reg_rd,                 // read strobe
   output var  logic [REG_DW-1:0] reg_rdata,              // read data, cycle after strobe
   output var  uhc_tx_s           tx,                     // byte stream to serialiser
   input  wire logic              tx_ready,               // serialiser takes byte
   input  wire uhc_hs_s           hs,                     // handshake from receiver
   input  wire logic              dp_pin,                 // D+ line level
   input  wire logic              dm_pin,                 // D- line level
   output var  logic              dplus_pulldown_enable,  // D+ pull-down on
   output var  logic              dminus_pulldown_enable, // D- pull-down on
   output var  logic              dplus_pullup_enable,    // D+ pull-up on
   output var  logic              dminus_pullup_enable,   // D- pull-up on
   output var  logic              vbus_power_request,     // ask supply for vbus
   output var  logic              vbus_discharge,         // vbus discharge resistor on
   output var  logic              low_speed_select,       // serialiser at low speed
   output var  logic              transfer_done_flag      // mirror of done flag
);
   logic [7:0]          main_ctrl_q;
   logic [7:0]          otg_q;
   logic [7:0]          ep0_q;
   logic [6:0]          addr_q;
   logic [7:0]          tok_q;
   logic [7:0]          irq_q;
   logic                bd_own_q;
   logic                bd_data01_q;
   logic [3:0]          bd_pid_q;
   logic [BD_CNT_W-1:0] bd_cnt_q;
   logic [7:0]          buf_q [MAX_BD_BYTES];
   logic [5:0]          wptr_q;
   uhc_state_e          state_q;
   logic [BD_CNT_W-1:0] idx_q;
   logic [6:0]          tok_addr_q;
   logic [3:0]          tok_ep_q;
   logic [3:0]          tok_pid_q;
   logic [7:0]          hs_timer_q;
   logic [1:0]          pins_s;
   logic                detach_evt;
   logic                se0;
   logic                wr_main, wr_otg, wr_ep0, wr_addr, wr_tok, wr_irq, wr_bd, wr_data;
   logic                host_en, launch, fire, hs_take, timeout, finish, nak_retry;
   logic [3:0]          finish_pid;
   logic [REG_DW-1:0]   rd_mux;

   localparam logic [7:0] HS_LIMIT = 8'(HS_TIMEOUT);

   uhc_sync2 #(.W(2)) u_pin_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .d       ({dp_pin, dm_pin}),
      .q       (pins_s)
   );

   assign se0 = !pins_s[1] && !pins_s[0];

   uhc_se0_timer #(.LIMIT_CYC(SE0_DETACH_CYC)) u_se0 (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .enable  (host_en),
      .se0     (se0),
      .detach  (detach_evt)
   );

   // register decode
   always_comb begin
      wr_main = reg_wr && reg_addr == OFF_MAIN_CTRL;
      wr_otg  = reg_wr && reg_addr == OFF_OTG_CTRL;
      wr_ep0  = reg_wr && reg_addr == OFF_EP0_CTRL;
      wr_addr = reg_wr && reg_addr == OFF_TGT_ADDR;
      wr_tok  = reg_wr && reg_addr == OFF_TOKEN;
      wr_irq  = reg_wr && reg_addr == OFF_IRQ_FLAGS;
      // descriptor is locked while a transfer runs
      wr_bd   = reg_wr && reg_addr == OFF_BD_CTRL && state_q == ST_IDLE;
      wr_data = reg_wr && reg_addr == OFF_BD_DATA && state_q == ST_IDLE;
   end

   // transfer control terms
   always_comb begin
      host_en   = main_ctrl_q[MAIN_HOST_EN];
      launch    = wr_tok && state_q == ST_IDLE && host_en && bd_own_q
                  && (reg_wdata[7:4] == PID_OUT || reg_wdata[7:4] == PID_SETUP);
      fire      = tx.valid && tx_ready;
      hs_take   = state_q == ST_WAIT_HS && hs.valid;
      timeout   = state_q == ST_WAIT_HS && !hs.valid && hs_timer_q == HS_LIMIT;
      nak_retry = hs_take && hs.pid == PID_NAK && !ep0_q[EP0_NAK_RETRY_DISABLE];
      finish    = (hs_take && !nak_retry) || timeout;
      finish_pid = timeout ? PID_ERR : hs.pid;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_ctrl_q <= MAIN_RESET;
         otg_q       <= OTG_RESET;
         ep0_q       <= EP0_RESET;
         addr_q      <= '0;
         tok_q       <= '0;
      end else if (ce) begin
         if (wr_main) main_ctrl_q <= reg_wdata[7:0] & (8'h01 << MAIN_HOST_EN);
         if (wr_otg)  otg_q <= reg_wdata[7:0] & 8'hFD;
         if (wr_ep0)  ep0_q <= reg_wdata[7:0];
         if (wr_addr) addr_q <= reg_wdata[6:0];
         if (wr_tok)  tok_q <= reg_wdata[7:0];
      end
   end

   // sticky flags: write one to clear, a new event wins over the clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= '0;
      end else if (ce) begin
         irq_q <= (irq_q & ~(wr_irq ? reg_wdata[7:0] : 8'h00))
                  | ({7'h00, detach_evt} << IRQ_DETACH)
                  | ({7'h00, finish} << IRQ_TRN_DONE)
                  | ({7'h00, finish && finish_pid == PID_STALL} << IRQ_STALL);
      end
   end

   // buffer descriptor and its data bytes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bd_own_q    <= 1'b0;
         bd_data01_q <= 1'b0;
         bd_pid_q    <= '0;
         bd_cnt_q    <= '0;
         wptr_q      <= '0;
      end else if (ce) begin
         if (wr_bd) begin
            bd_own_q    <= reg_wdata[BD_OWN];
            bd_data01_q <= reg_wdata[BD_DATA01];
            // counts above the buffer size are clipped to it
            bd_cnt_q    <= (reg_wdata[BD_CNT_W-1:0] > BD_CNT_W'(MAX_BD_BYTES))
                           ? BD_CNT_W'(MAX_BD_BYTES) : reg_wdata[BD_CNT_W-1:0];
            wptr_q      <= '0;
         end else if (wr_data && wptr_q != 6'h3F) begin
            wptr_q <= wptr_q + 1'b1;
         end
         if (finish) begin
            bd_own_q <= 1'b0;
            bd_pid_q <= finish_pid;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (ce && wr_data) begin
         buf_q[wptr_q] <= reg_wdata[7:0];
      end
   end

   // transmit sequencing: token bytes, data pid, data bytes, then wait
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= ST_IDLE;
         idx_q      <= '0;
         tx         <= '0;
         tok_addr_q <= '0;
         tok_ep_q   <= '0;
         tok_pid_q  <= '0;
         hs_timer_q <= '0;
      end else if (ce) begin
         unique case (state_q)
            ST_IDLE: begin
               if (launch) begin
                  tok_pid_q  <= reg_wdata[7:4];
                  tok_ep_q   <= reg_wdata[3:0];
                  tok_addr_q <= addr_q;
                  state_q    <= ST_TOKEN;
                  idx_q      <= '0;
                  tx         <= '{valid: 1'b1, data: {~reg_wdata[7:4], reg_wdata[7:4]}, last: 1'b0};
               end
            end
            ST_TOKEN: begin
               if (fire) begin
                  if (idx_q == BD_CNT_W'(0)) begin
                     tx.data <= {tok_ep_q[0], tok_addr_q};
                     idx_q   <= idx_q + 1'b1;
                  end else if (idx_q == BD_CNT_W'(1)) begin
                     tx.data <= {5'h00, tok_ep_q[3:1]};
                     tx.last <= 1'b1;
                     idx_q   <= idx_q + 1'b1;
                  end else begin
                     state_q <= ST_DATA;
                     idx_q   <= '0;
                     tx.data <= bd_data01_q ? {~PID_DATA1, PID_DATA1} : {~PID_DATA0, PID_DATA0};
                     tx.last <= bd_cnt_q == '0;
                  end
               end
            end
            ST_DATA: begin
               if (fire) begin
                  if (tx.last) begin
                     state_q    <= ST_WAIT_HS;
                     tx         <= '0;
                     hs_timer_q <= '0;
                  end else begin
                     tx.data <= buf_q[idx_q[5:0]];
                     tx.last <= (idx_q + 1'b1) == bd_cnt_q;
                     idx_q   <= idx_q + 1'b1;
                  end
               end
            end
            ST_WAIT_HS: begin
               hs_timer_q <= hs_timer_q + 1'b1;
               if (nak_retry) begin
                  // resend the same token and data
                  state_q <= ST_TOKEN;
                  idx_q   <= '0;
                  tx      <= '{valid: 1'b1, data: {~tok_pid_q, tok_pid_q}, last: 1'b0};
               end else if (finish) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // pin controls; a one-cycle lag behind the register is harmless at setup
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dplus_pulldown_enable  <= 1'b0;
         dminus_pulldown_enable <= 1'b0;
         dplus_pullup_enable    <= 1'b0;
         dminus_pullup_enable   <= 1'b0;
         vbus_power_request     <= 1'b0;
         vbus_discharge         <= 1'b0;
         low_speed_select       <= 1'b0;
         transfer_done_flag     <= 1'b0;
      end else if (ce) begin
         if (otg_q[OTG_EN]) begin
            dplus_pulldown_enable  <= otg_q[OTG_DP_PD];
            dminus_pulldown_enable <= otg_q[OTG_DM_PD];
         end else begin
            dplus_pulldown_enable  <= host_en;
            dminus_pulldown_enable <= host_en;
         end
         dplus_pullup_enable  <= otg_q[OTG_DP_PU];
         dminus_pullup_enable <= otg_q[OTG_DM_PU];
         vbus_power_request   <= otg_q[OTG_VBUS_ON];
         vbus_discharge       <= otg_q[OTG_VBUS_DIS];
         low_speed_select     <= ep0_q[EP0_LOW_SPEED_SELECT];
         transfer_done_flag   <= irq_q[IRQ_TRN_DONE];
      end
   end

   always_comb begin
      rd_mux = '0;
      unique case (reg_addr)
         OFF_MAIN_CTRL: rd_mux = {8'h00, main_ctrl_q};
         OFF_OTG_CTRL:  rd_mux = {8'h00, otg_q};
         OFF_EP0_CTRL:  rd_mux = {8'h00, ep0_q};
         OFF_TGT_ADDR:  rd_mux = {9'h000, addr_q};
         OFF_TOKEN:     rd_mux = {8'h00, tok_q};
         OFF_IRQ_FLAGS: rd_mux = {8'h00, irq_q};
         OFF_BD_CTRL:   rd_mux = {bd_own_q, bd_data01_q, bd_pid_q, 3'h0, bd_cnt_q};
         OFF_STATUS:    rd_mux = {10'h000, pins_s, se0, host_en, state_q};
         default:       rd_mux = '0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (ce) begin
         reg_rdata <= reg_rd ? rd_mux : '0;
      end
   end

   pulldown_host_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ce && !otg_q[OTG_EN] && host_en |=> dplus_pulldown_enable && dminus_pulldown_enable)
      else $error("host pull-downs not engaged");

   pulldown_otg_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ce && otg_q[OTG_EN] |=> dplus_pulldown_enable == $past(otg_q[OTG_DP_PD])
                              && dminus_pulldown_enable == $past(otg_q[OTG_DM_PD]))
      else $error("otg pull-downs not following their bits");

   speed_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ce |=> low_speed_select == $past(ep0_q[EP0_LOW_SPEED_SELECT]))
      else $error("low speed output does not follow control");

   nak_retry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ce && hs_take && hs.pid == PID_NAK && !ep0_q[EP0_NAK_RETRY_DISABLE]
      |=> state_q == ST_TOKEN && bd_own_q && tx.valid && !irq_q[IRQ_TRN_DONE] || $past(irq_q[IRQ_TRN_DONE]))
      else $error("nak not retried");

   token_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_q == ST_TOKEN && tx.valid && idx_q == BD_CNT_W'(1) |-> tx.data[6:0] == tok_addr_q)
      else $error("token carries wrong address");

   token_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ce && launch |=> state_q == ST_TOKEN && tx.valid && tx.data[3:0] == $past(reg_wdata[7:4]))
      else $error("token write did not start transmit");

   done_return_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ce && finish |=> !bd_own_q && irq_q[IRQ_TRN_DONE] && state_q == ST_IDLE)
      else $error("completion not reported");

   pid_writeback_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ce && finish |=> bd_pid_q == $past(finish_pid))
      else $error("handshake not written to descriptor");

   vbus_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ce && !otg_q[OTG_VBUS_ON] |=> !vbus_power_request)
      else $error("vbus request still on");

   flag_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ce && irq_q[IRQ_DETACH] && !(wr_irq && reg_wdata[IRQ_DETACH]) |=> irq_q[IRQ_DETACH])
      else $error("detach flag lost");
endmodule : uhc_host_ctrl
`default_nettype wire

/* dv/uhc_peer_model.sv */
// attached peripheral model: takes host bytes, answers handshakes, drives line levels
`timescale 1ns/10ps
`default_nettype none
module uhc_peer_model
   import uhc_pkg::*;
(
   input  wire logic       sys_clk,  // system clock
   input  wire logic       rst_n,    // async reset, active low
   input  wire uhc_tx_s    tx,       // bytes from host
   output var  logic       tx_ready, // byte taken this cycle
   output var  uhc_hs_s    hs,       // handshake back to host
   output var  logic       dp_pin,   // D+ level
   output var  logic       dm_pin,   // D- level
   input  wire logic       arm,      // clear log and answer count
   input  wire logic       slow,     // accept only every other cycle
   input  wire logic       mute,     // never answer
   input  wire logic       se0,      // hold both lines low
   input  wire logic [3:0] n_nak,    // naks before final answer
   input  wire logic [3:0] fin_pid   // final answer
);
   logic [7:0] log_q [0:15];
   logic [3:0] log_n_q;
   logic [3:0] ans_n_q;
   logic [1:0] dly_q;
   logic       phase_q;
   logic       tog_q;
   assign tx_ready = !slow || tog_q;
   // idle full-speed J state when not forcing se0
   assign dp_pin = !se0;
   assign dm_pin = 1'b0;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         {log_n_q, ans_n_q, dly_q, phase_q, tog_q} <= '0;
         hs <= '0;
      end else begin
         tog_q <= !tog_q;
         hs.valid <= 1'b0;
         // released pid lines toggle so no stale value looks valid
         hs.pid <= ~hs.pid;
         if (arm) begin
            {log_n_q, ans_n_q, phase_q} <= '0;
         end
         if (tx.valid && tx_ready) begin
            log_q[log_n_q] <= tx.data;
            log_n_q <= log_n_q + 4'h1;
            if (tx.last) begin
               phase_q <= !phase_q;
               if (phase_q && !mute) dly_q <= 2'h2;
            end
         end
         if (dly_q != 2'h0) begin
            dly_q <= dly_q - 2'h1;
            if (dly_q == 2'h1) begin
               hs.valid <= 1'b1;
               hs.pid <= (ans_n_q < n_nak) ? PID_NAK : fin_pid;
               ans_n_q <= ans_n_q + 4'h1;
            end
         end
      end
   end
endmodule : uhc_peer_model
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench of the usb host transfer controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import uhc_pkg::*;
   logic sys_clk, rst_n, reg_wr, reg_rd, arm, slow, mute, se0, tx_ready, dp_pin, dm_pin;
   logic [REG_AW-1:0] reg_addr;
   logic [REG_DW-1:0] reg_wdata, reg_rdata, v;
   logic [3:0] n_nak, fin_pid;
   uhc_tx_s tx;
   uhc_hs_s hs;
   logic dplus_pulldown_enable, dminus_pulldown_enable, vbus_power_request, low_speed_select, transfer_done_flag;
   logic ce, dplus_pullup_enable, dminus_pullup_enable, vbus_discharge;
   // bytes the peer must log for the first transfer: token, address, endpoint, data pid, two data bytes
   logic [7:0] exp_log [0:5] = '{{~PID_OUT, PID_OUT}, 8'h05, 8'h00, {~PID_DATA0, PID_DATA0}, 8'hA5, 8'h5A};
   int fails, tests_run;
   uhc_host_ctrl #(.HS_TIMEOUT(4)) dut_u (.sys_clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .tx, .tx_ready, .hs, .dp_pin, .dm_pin, .dplus_pulldown_enable, .dminus_pulldown_enable,
      .dplus_pullup_enable, .dminus_pullup_enable, .vbus_power_request, .vbus_discharge, .low_speed_select,
      .transfer_done_flag);
   uhc_peer_model peer_u (.sys_clk, .rst_n, .tx, .tx_ready, .hs, .dp_pin, .dm_pin, .arm, .slow, .mute, .se0,
      .n_nak, .fin_pid);
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      chk(v, exp);
   endtask : rchk
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : settle
   // one OUT transfer of two bytes, then descriptor and flag checks
   task automatic xfer(input logic [15:0] bd, input logic [3:0] exp_pid, input logic [7:0] exp_irq);
      arm <= 1'b1;
      @(posedge sys_clk);
      arm <= 1'b0;
      wr(OFF_BD_CTRL, bd);
      wr(OFF_BD_DATA, 16'h00A5);
      wr(OFF_BD_DATA, 16'h005A);
      wr(OFF_TOKEN, 16'h0010);
      for (int i = 0; i < 400 && transfer_done_flag !== 1'b1; i++) @(posedge sys_clk);
      if (transfer_done_flag !== 1'b1) begin
         fails++;
         finish_test();
      end
      rchk(OFF_IRQ_FLAGS, {8'h00, exp_irq});
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, OFF_BD_CTRL};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      chk({11'h000, v[15], v[13:10]}, {12'h000, exp_pid});
      wr(OFF_IRQ_FLAGS, {8'h00, exp_irq});
      rchk(OFF_IRQ_FLAGS, 16'h0000);
   endtask : xfer
   initial begin
      repeat (100000) @(posedge sys_clk);
      fails++;
      finish_test();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, arm, slow, mute, se0, reg_addr, reg_wdata} = '0;
      n_nak = 4'h0;
      ce = 1'b1;
      fin_pid = PID_ACK;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      rchk(OFF_OTG_CTRL, {8'h00, OTG_RESET});
      chk({14'h0, dplus_pulldown_enable, dminus_pulldown_enable}, 16'h0000);
      wr(OFF_MAIN_CTRL, 16'h0008);
      settle(3);
      chk({14'h0, dplus_pulldown_enable, dminus_pulldown_enable}, 16'h0003);
      wr(OFF_OTG_CTRL, 16'h0024);
      settle(3);
      chk({14'h0, dplus_pulldown_enable, dminus_pulldown_enable}, 16'h0002);
      wr(OFF_OTG_CTRL, 16'h0008);
      settle(3);
      chk({13'h0, vbus_power_request, dplus_pulldown_enable, dminus_pulldown_enable}, 16'h0007);
      wr(OFF_OTG_CTRL, 16'h0000);
      settle(3);
      chk({15'h0, vbus_power_request}, 16'h0000);
      wr(8'h30, 16'hFFFF);
      rchk(8'h30, 16'h0000);
      wr(OFF_TGT_ADDR, 16'h00FF);
      rchk(OFF_TGT_ADDR, 16'h007F);
      // a write while the clock enable is low must not land
      ce <= 1'b0;
      wr(OFF_TGT_ADDR, 16'h0011);
      ce <= 1'b1;
      rchk(OFF_TGT_ADDR, 16'h007F);
      wr(OFF_EP0_CTRL, 16'h009D);
      settle(3);
      chk({15'h0, low_speed_select}, 16'h0001);
      wr(OFF_EP0_CTRL, 16'h001D);
      wr(OFF_TGT_ADDR, 16'h0005);
      slow <= 1'b1;
      xfer(16'h8002, PID_ACK, 8'h08);
      foreach (peer_u.log_q[i]) if (i < 6) chk({8'h00, peer_u.log_q[i]}, {8'h00, exp_log[i]});
      slow <= 1'b0;
      n_nak <= 4'h2;
      xfer(16'h8002, PID_ACK, 8'h08);
      chk({12'h000, peer_u.ans_n_q}, 16'h0003);
      n_nak <= 4'h0;
      fin_pid <= PID_STALL;
      wr(OFF_EP0_CTRL, 16'h005D);
      xfer(16'hC002, PID_STALL, 8'h88);
      chk({8'h00, peer_u.log_q[3]}, 16'h004B);
      mute <= 1'b1;
      xfer(16'h8002, PID_ERR, 8'h08);
      mute <= 1'b0;
      se0 <= 1'b1;
      settle(20);
      se0 <= 1'b0;
      rchk(OFF_IRQ_FLAGS, 16'h0000);
      se0 <= 1'b1;
      settle(32);
      se0 <= 1'b0;
      settle(10);
      rchk(OFF_IRQ_FLAGS, 16'h0001);
      wr(OFF_IRQ_FLAGS, 16'h0001);
      rchk(OFF_IRQ_FLAGS, 16'h0000);
      // session request as a b-device: lines low and vbus discharged, then pulse D+ through the pull-up
      se0 <= 1'b1;
      wr(OFF_OTG_CTRL, 16'h0001);
      settle(3);
      chk({15'h0, vbus_discharge}, 16'h0001);
      rchk(OFF_STATUS, 16'h000C);
      se0 <= 1'b0;
      wr(OFF_OTG_CTRL, 16'h0080);
      settle(3);
      chk({13'h0, dplus_pullup_enable, dminus_pullup_enable, vbus_discharge}, 16'h0004);
      wr(OFF_OTG_CTRL, 16'h0040);
      settle(3);
      chk({14'h0, dplus_pullup_enable, dminus_pullup_enable}, 16'h0001);
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
